// >>> rtl/stf_top.sv
// serial time telegram formatter: builds time and capture telegrams
// and sends them on an asynchronous serial line; assumes BCD time
// fields that already show the new second when sec_tick pulses
//
// Chosen here: the AHB-Lite slave port and the address map.
`timescale 1ns/1ps
module stf_top
  import stf_pkg::*;
(
  // clock and reset
  input logic hclk,
  input logic hresetn,
  // ahb-lite slave
  input logic hsel,
  input logic [31:0] haddr,
  input logic [1:0] htrans,
  input logic hwrite,
  input logic [2:0] hsize,
  input logic [31:0] hwdata,
  input logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // time of day source
  input logic sec_tick,
  input stf_time_type tm,
  input stf_stat_type st,
  input stf_pos_type pos,
  input logic [27:0] frac,
  // capture inputs
  input logic [1:0] cap_in,
  // serial line
  input logic rxd,
  output logic txd
);

  // ****************************************
  // registers
  // ****************************************
  logic [7:0] ctrl_q;
  logic [17:0] baud_q;
  logic [7:0] rx_data_q;
  logic pend_q;
  logic [11:0] addr_q;
  logic wr_q;
  logic hreadyout_q;
  logic [31:0] hrdata_q;
  stf_state_type st_q;
  logic [1:0] kind_q;
  logic [6:0] idx_q;
  stf_snap_type snap_q;
  logic [11:0] sh_q;
  logic [3:0] nb_q;
  logic [17:0] bc_q;
  logic txd_q;
  logic req_q;
  logic [1:0] cap_prev_q, cap_pend_q;
  stf_snap_type cap_snap_q [2];
  logic rx_act_q;
  logic [17:0] rx_cnt_q;
  logic [3:0] rx_bit_q;
  logic [7:0] rx_sh_q;

  // ****************************************
  // character builder
  // ****************************************
  function automatic logic [7:0] dg(input logic [3:0] b);
    return {4'h3, b};
  endfunction

  function automatic logic [7:0] bz(input logic [3:0] b,
                                   input logic bl);
    return bl ? CH_SP : {4'h3, b};
  endfunction

  function automatic logic [7:0] tel_chr(input logic [1:0] k,
                                        input logic [6:0] i,
                                        input stf_snap_type s);
    logic [7:0] c;
    logic [7:0] tzc;
    logic la2, la1, lo2, lo1, al3, al2, al1;
    la2 = s.p.lat[27:24] == 4'h0;
    la1 = la2 && s.p.lat[23:20] == 4'h0;
    lo2 = s.p.lon[27:24] == 4'h0;
    lo1 = lo2 && s.p.lon[23:20] == 4'h0;
    al3 = s.p.alt[15:12] == 4'h0;
    al2 = al3 && s.p.alt[11:8] == 4'h0;
    al1 = al2 && s.p.alt[7:4] == 4'h0;
    tzc = (s.s.tz == TZ_UTC) ? 8'h55 :
          (s.s.tz == TZ_CEST) ? 8'h53 : CH_SP;
    c = CH_SP;
    case (k)
      KIND_STD:
      begin
        case (i)
          7'd0: c = CH_STX;
          7'd1: c = 8'h44;
          7'd2: c = CH_COL;
          7'd3: c = dg(s.t.day[7:4]);
          7'd4: c = dg(s.t.day[3:0]);
          7'd5: c = CH_DOT;
          7'd6: c = dg(s.t.mon[7:4]);
          7'd7: c = dg(s.t.mon[3:0]);
          7'd8: c = CH_DOT;
          7'd9: c = dg(s.t.yr[7:4]);
          7'd10: c = dg(s.t.yr[3:0]);
          7'd11: c = CH_SEMI;
          7'd12: c = 8'h54;
          7'd13: c = CH_COL;
          7'd14: c = dg(s.t.dow);
          7'd15: c = CH_SEMI;
          7'd16: c = 8'h55;
          7'd17: c = CH_COL;
          7'd18: c = dg(s.t.hr[7:4]);
          7'd19: c = dg(s.t.hr[3:0]);
          7'd20: c = CH_DOT;
          7'd21: c = dg(s.t.mn[7:4]);
          7'd22: c = dg(s.t.mn[3:0]);
          7'd23: c = CH_DOT;
          7'd24: c = dg(s.t.sc[7:4]);
          7'd25: c = dg(s.t.sc[3:0]);
          7'd26: c = CH_SEMI;
          7'd27: c = s.s.sync ? CH_SP : CH_HASH;
          7'd28: c = s.s.pos_ok ? CH_SP : CH_HASH;
          7'd29: c = tzc;
          7'd30: c = s.s.ann_leap ? 8'h41 :
                     s.s.ann_dst ? 8'h21 : CH_SP;
          7'd31: c = CH_ETX;
          default: c = CH_SP;
        endcase
      end
      KIND_NTP:
      begin
        case (i)
          7'd0: c = CH_STX;
          7'd1: c = dg(s.t.day[7:4]);
          7'd2: c = dg(s.t.day[3:0]);
          7'd3: c = CH_DOT;
          7'd4: c = dg(s.t.mon[7:4]);
          7'd5: c = dg(s.t.mon[3:0]);
          7'd6: c = CH_DOT;
          7'd7: c = dg(s.t.yr[7:4]);
          7'd8: c = dg(s.t.yr[3:0]);
          7'd9: c = CH_SEMI;
          7'd11: c = dg(s.t.dow);
          7'd12: c = CH_SEMI;
          7'd14: c = dg(s.t.hr[7:4]);
          7'd15: c = dg(s.t.hr[3:0]);
          7'd16: c = CH_COL;
          7'd17: c = dg(s.t.mn[7:4]);
          7'd18: c = dg(s.t.mn[3:0]);
          7'd19: c = CH_COL;
          7'd20: c = dg(s.t.sc[7:4]);
          7'd21: c = dg(s.t.sc[3:0]);
          7'd22: c = CH_SEMI;
          7'd24: c = s.s.off_neg ? 8'h2d : 8'h2b;
          7'd25: c = dg(s.s.off_hr[7:4]);
          7'd26: c = dg(s.s.off_hr[3:0]);
          7'd27: c = CH_COL;
          7'd28: c = dg(s.s.off_mn[7:4]);
          7'd29: c = dg(s.s.off_mn[3:0]);
          7'd30: c = CH_SEMI;
          7'd32: c = s.s.sync ? CH_SP : CH_HASH;
          7'd33: c = s.s.pos_ok ? CH_SP : CH_HASH;
          7'd34: c = tzc;
          7'd35: c = s.s.ann_dst ? 8'h21 : CH_SP;
          7'd36: c = s.s.ann_leap ? 8'h41 : CH_SP;
          7'd38: c = (s.s.leap_now && s.t.sc == 8'h60) ?
                     8'h4c : CH_SP;
          7'd39: c = CH_SEMI;
          7'd40: c = bz(s.p.lat[27:24], la2);
          7'd41: c = bz(s.p.lat[23:20], la1);
          7'd42: c = dg(s.p.lat[19:16]);
          7'd43: c = CH_DOT;
          7'd44: c = dg(s.p.lat[15:12]);
          7'd45: c = dg(s.p.lat[11:8]);
          7'd46: c = dg(s.p.lat[7:4]);
          7'd47: c = dg(s.p.lat[3:0]);
          7'd48: c = s.p.south ? 8'h53 : 8'h4e;
          7'd50: c = bz(s.p.lon[27:24], lo2);
          7'd51: c = bz(s.p.lon[23:20], lo1);
          7'd52: c = dg(s.p.lon[19:16]);
          7'd53: c = CH_DOT;
          7'd54: c = dg(s.p.lon[15:12]);
          7'd55: c = dg(s.p.lon[11:8]);
          7'd56: c = dg(s.p.lon[7:4]);
          7'd57: c = dg(s.p.lon[3:0]);
          7'd58: c = s.p.west ? 8'h57 : 8'h45;
          7'd60: c = bz(s.p.alt[15:12], al3);
          7'd61: c = bz(s.p.alt[11:8], al2);
          7'd62: c = bz(s.p.alt[7:4], al1);
          7'd63: c = dg(s.p.alt[3:0]);
          7'd64: c = 8'h6d;
          7'd65: c = CH_ETX;
          default: c = CH_SP;
        endcase
      end
      KIND_CAP:
      begin
        case (i)
          7'd0: c = 8'h43;
          7'd1: c = 8'h48;
          7'd2: c = dg({3'h0, s.ch});
          7'd4: c = dg(s.t.day[7:4]);
          7'd5: c = dg(s.t.day[3:0]);
          7'd6: c = CH_DOT;
          7'd7: c = dg(s.t.mon[7:4]);
          7'd8: c = dg(s.t.mon[3:0]);
          7'd9: c = CH_DOT;
          7'd10: c = dg(s.t.yr[7:4]);
          7'd11: c = dg(s.t.yr[3:0]);
          7'd13: c = dg(s.t.hr[7:4]);
          7'd14: c = dg(s.t.hr[3:0]);
          7'd15: c = CH_COL;
          7'd16: c = dg(s.t.mn[7:4]);
          7'd17: c = dg(s.t.mn[3:0]);
          7'd18: c = CH_COL;
          7'd19: c = dg(s.t.sc[7:4]);
          7'd20: c = dg(s.t.sc[3:0]);
          7'd21: c = CH_DOT;
          7'd22: c = dg(s.frac[27:24]);
          7'd23: c = dg(s.frac[23:20]);
          7'd24: c = dg(s.frac[19:16]);
          7'd25: c = dg(s.frac[15:12]);
          7'd26: c = dg(s.frac[11:8]);
          7'd27: c = dg(s.frac[7:4]);
          7'd28: c = dg(s.frac[3:0]);
          7'd29: c = CH_CR;
          7'd30: c = CH_LF;
          default: c = CH_SP;
        endcase
      end
      default: c = CH_SP;
    endcase
    return c;
  endfunction

  // ****************************************
  // decode and selection
  // ****************************************
  wire en = ctrl_q[CTRL_EN_BIT];
  wire [1:0] mode = ctrl_q[CTRL_MODE_LSB +: 2];
  wire seven = ctrl_q[CTRL_SEVEN_BIT];
  wire [1:0] par = ctrl_q[CTRL_PAR_LSB +: 2];
  wire two = ctrl_q[CTRL_TWO_BIT];
  wire par_en = par != 2'h0;
  wire idle = st_q == ST_IDLE;
  wire due = (mode == MODE_SEC) || (mode == MODE_REQ && req_q) ||
             (mode == MODE_MIN && tm.sc == 8'h00);
  wire start_tm = idle && en && sec_tick && due;
  wire start_cap = idle && en && !sec_tick && |cap_pend_q;
  wire cap_ch = !cap_pend_q[0];
  wire [1:0] cap_fall = cap_prev_q & ~cap_in;
  wire [6:0] last = (kind_q == KIND_NTP) ? LAST_NTP :
                    (kind_q == KIND_CAP) ? LAST_CAP : LAST_STD;
  wire [7:0] chr = tel_chr(kind_q, idx_q, snap_q);
  wire pin = seven ? ^chr[6:0] : ^chr;
  wire pbit = (par == PAR_EVEN) ? pin : ~pin;
  wire [7:0] lo8 = seven ? {par_en ? pbit : 1'b1, chr[6:0]} : chr;
  wire b9 = (!seven && par_en) ? pbit : 1'b1;
  wire [11:0] frame = {2'b11, b9, lo8, 1'b0};
  wire [3:0] nbits = 4'd10 - {3'h0, seven} + {3'h0, par_en} +
                     {3'h0, two};
  wire bit_end = bc_q == 18'h0;
  wire chr_end = (st_q == ST_SHIFT) && bit_end && nb_q == 4'h1;
  wire rx_tick = rx_act_q && rx_cnt_q == 18'h0;
  wire rx_done = rx_tick && rx_bit_q == 4'd9;
  wire rx_hit = rx_done && rx_sh_q[6:0] == CH_REQ[6:0] &&
                mode == MODE_REQ;
  wire accept = hsel && hready && htrans[1];
  wire [31:0] rd = (addr_q == CTRL_OFF) ? {24'h0, ctrl_q} :
                   (addr_q == BAUD_OFF) ? {14'h0, baud_q} :
                   (addr_q == STAT_OFF) ? {26'h0, cap_pend_q, req_q,
                                           kind_q, !idle} :
                   (addr_q == RXD_OFF) ? {24'h0, rx_data_q} :
                   32'h0;
  stf_snap_type now_snap;
  assign now_snap = '{t: tm, s: st, p: pos, frac: frac, ch: 1'b0};

  assign hreadyout = hreadyout_q;
  assign hresp = 1'b0;
  assign hrdata = hrdata_q;
  assign txd = txd_q;

  // ****************************************
  // bus slave, one wait state per transfer
  // ****************************************
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      pend_q <= 1'b0;
      addr_q <= 12'h000;
      wr_q <= 1'b0;
      hreadyout_q <= 1'b1;
    end
    else
    begin
      pend_q <= accept;
      hreadyout_q <= !accept;
      if (accept)
      begin
        addr_q <= (haddr[31:12] == 20'h0) ? haddr[11:0] : 12'hfff;
        wr_q <= hwrite;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      ctrl_q <= CTRL_RST;
      baud_q <= BAUD_RST;
      hrdata_q <= 32'h0;
    end
    else if (pend_q)
    begin
      hrdata_q <= wr_q ? hrdata_q : rd;
      if (wr_q && addr_q == CTRL_OFF)
        ctrl_q <= hwdata[7:0];
      if (wr_q && addr_q == BAUD_OFF)
        baud_q <= hwdata[17:0];
    end
  end

  // ****************************************
  // capture inputs and request flag
  // ****************************************
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      cap_prev_q <= 2'b11;
      cap_pend_q <= 2'b00;
      req_q <= 1'b0;
      for (int c = 0; c < 2; c++)
        cap_snap_q[c] <= '0;
    end
    else
    begin
      cap_prev_q <= cap_in;
      req_q <= rx_hit || (req_q && !start_tm);
      for (int c = 0; c < 2; c++)
      begin
        cap_pend_q[c] <= cap_fall[c] || (cap_pend_q[c] &&
                         !(start_cap && cap_ch == c[0]));
        if (cap_fall[c])
        begin
          cap_snap_q[c] <= now_snap;
          cap_snap_q[c].ch <= c[0];
        end
      end
    end
  end

  // ****************************************
  // telegram sequencer and transmitter
  // ****************************************
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      st_q <= ST_IDLE;
      kind_q <= KIND_STD;
      idx_q <= 7'h0;
      snap_q <= '0;
    end
    else
    begin
      case (st_q)
        ST_IDLE:
        begin
          idx_q <= 7'h0;
          if (start_tm)
          begin
            snap_q <= now_snap;
            kind_q <= ctrl_q[CTRL_NTP_BIT] ? KIND_NTP : KIND_STD;
            st_q <= ST_LOAD;
          end
          else if (start_cap)
          begin
            snap_q <= cap_snap_q[cap_ch];
            kind_q <= KIND_CAP;
            st_q <= ST_LOAD;
          end
        end
        ST_LOAD: st_q <= ST_SHIFT;
        ST_SHIFT:
        begin
          if (chr_end)
          begin
            idx_q <= idx_q + 7'h1;
            st_q <= (idx_q == last) ? ST_IDLE : ST_LOAD;
          end
        end
        default: st_q <= ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      sh_q <= 12'hfff;
      nb_q <= 4'h0;
      bc_q <= 18'h0;
      txd_q <= 1'b1;
    end
    else
    begin
      txd_q <= (st_q == ST_SHIFT) ? sh_q[0] : 1'b1;
      if (st_q == ST_LOAD)
      begin
        sh_q <= frame;
        nb_q <= nbits;
        bc_q <= baud_q;
      end
      else if (st_q == ST_SHIFT)
      begin
        bc_q <= bit_end ? baud_q : bc_q - 18'h1;
        if (bit_end)
        begin
          sh_q <= {1'b1, sh_q[11:1]};
          nb_q <= nb_q - 4'h1;
        end
      end
    end
  end

  // ****************************************
  // request receiver
  // ****************************************
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      rx_act_q <= 1'b0;
      rx_cnt_q <= 18'h0;
      rx_bit_q <= 4'h0;
      rx_sh_q <= 8'h0;
      rx_data_q <= 8'h0;
    end
    else if (!rx_act_q)
    begin
      rx_act_q <= !rxd;
      rx_cnt_q <= {1'b0, baud_q[17:1]};
      rx_bit_q <= 4'h0;
    end
    else if (rx_tick)
    begin
      rx_cnt_q <= baud_q;
      rx_bit_q <= rx_bit_q + 4'h1;
      rx_act_q <= !(rx_done || (rx_bit_q == 4'h0 && rxd));
      if (rx_bit_q != 4'h0 && !rx_done)
        rx_sh_q <= {rxd, rx_sh_q[7:1]};
      if (rx_done)
        rx_data_q <= rx_sh_q;
    end
    else
      rx_cnt_q <= rx_cnt_q - 18'h1;
  end

  // ****************************************
  // assertions
  // ****************************************
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);

  chk_stx_at_tick: assert property (
    start_tm |-> ##3 (!txd_q && kind_q != KIND_CAP && chr == CH_STX))
    else $error("start bit not on line after second tick");
  chk_std_last_etx: assert property (
    (kind_q == KIND_STD && idx_q == LAST_STD) |-> chr == CH_ETX)
    else $error("standard telegram does not end with etx");
  chk_cap_crlf: assert property (
    (kind_q == KIND_CAP && idx_q == 7'd29) |-> chr == CH_CR)
    else $error("capture telegram lacks carriage return");
  chk_sync_char: assert property (
    (kind_q == KIND_STD && idx_q == 7'd27) |->
      chr == (snap_q.s.sync ? CH_SP : CH_HASH))
    else $error("sync character wrong");
  chk_leap_char: assert property (
    (kind_q == KIND_NTP && idx_q == 7'd38 && snap_q.t.sc != 8'h60)
      |-> chr == CH_SP)
    else $error("leap character outside leap second");
  chk_telegram_end: assert property (
    (chr_end && idx_q == last) |=> st_q == ST_IDLE ##1 st_q != ST_SHIFT)
    else $error("sequencer did not stop after last character");
  chk_cap_edge: assert property (
    (cap_fall[0] && !start_cap) |=> cap_pend_q[0])
    else $error("capture edge lost");
  chk_minute_mode: assert property (
    (start_tm && mode == MODE_MIN) |=> snap_q.t.sc == 8'h00)
    else $error("minute telegram not at second zero");
  chk_bit_time: assert property (
    (st_q == ST_SHIFT && !bit_end) |=> $stable(sh_q))
    else $error("bit shifted before bit time elapsed");

  cov_ntp_sent: cover property (chr_end && kind_q == KIND_NTP);
  cov_cap_sent: cover property (chr_end && kind_q == KIND_CAP);
  cov_request: cover property (req_q && start_tm);
  cov_leap: cover property (st_q == ST_LOAD && chr == 8'h4c);

endmodule

// >>> rtl/stf_pkg.sv
// constants, field layouts and carriers of the serial time telegram
// formatter; assumes a 50 MHz system clock and a 32-bit AHB-Lite bus
package stf_pkg;

  // ****************************************
  // clock and serial timing
  // ****************************************
  localparam int CLK_HZ = 50_000_000;
  localparam int BAUD_DFLT = 9600;
  localparam logic [17:0] BAUD_RST = 18'(CLK_HZ / BAUD_DFLT - 1);

  // ****************************************
  // register offsets, fields, reset values
  // ****************************************
  localparam logic [11:0] CTRL_OFF = 12'h000;
  localparam logic [11:0] BAUD_OFF = 12'h004;
  localparam logic [11:0] STAT_OFF = 12'h008;
  localparam logic [11:0] RXD_OFF = 12'h00c;
  localparam int CTRL_EN_BIT = 0;
  localparam int CTRL_MODE_LSB = 1;
  localparam int CTRL_NTP_BIT = 3;
  localparam int CTRL_SEVEN_BIT = 4;
  localparam int CTRL_PAR_LSB = 5;
  localparam int CTRL_TWO_BIT = 7;
  localparam logic [7:0] CTRL_RST = 8'h01;

  // ****************************************
  // modes, kinds, zones, lengths
  // ****************************************
  localparam logic [1:0] MODE_SEC = 2'h0;
  localparam logic [1:0] MODE_MIN = 2'h1;
  localparam logic [1:0] MODE_REQ = 2'h2;
  localparam logic [1:0] PAR_EVEN = 2'h1;
  localparam logic [1:0] KIND_STD = 2'h0;
  localparam logic [1:0] KIND_NTP = 2'h1;
  localparam logic [1:0] KIND_CAP = 2'h2;
  localparam logic [1:0] TZ_CET = 2'h0;
  localparam logic [1:0] TZ_CEST = 2'h1;
  localparam logic [1:0] TZ_UTC = 2'h2;
  localparam logic [6:0] LAST_STD = 7'd31;
  localparam logic [6:0] LAST_NTP = 7'd65;
  localparam logic [6:0] LAST_CAP = 7'd30;

  // ****************************************
  // characters
  // ****************************************
  localparam logic [7:0] CH_STX = 8'h02;
  localparam logic [7:0] CH_ETX = 8'h03;
  localparam logic [7:0] CH_CR = 8'h0d;
  localparam logic [7:0] CH_LF = 8'h0a;
  localparam logic [7:0] CH_SP = 8'h20;
  localparam logic [7:0] CH_HASH = 8'h23;
  localparam logic [7:0] CH_COL = 8'h3a;
  localparam logic [7:0] CH_DOT = 8'h2e;
  localparam logic [7:0] CH_SEMI = 8'h3b;
  localparam logic [7:0] CH_REQ = 8'h3f;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_LOAD = 3'b010,
    ST_SHIFT = 3'b100
  } stf_state_type;

  typedef struct packed {
    logic [7:0] day, mon, yr, hr, mn, sc;
    logic [3:0] dow;
  } stf_time_type;

  typedef struct packed {
    logic sync, pos_ok;
    logic [1:0] tz;
    logic ann_dst, ann_leap, leap_now, off_neg;
    logic [7:0] off_hr, off_mn;
  } stf_stat_type;

  typedef struct packed {
    logic [27:0] lat;
    logic south;
    logic [27:0] lon;
    logic west;
    logic [15:0] alt;
  } stf_pos_type;

  typedef struct packed {
    stf_time_type t;
    stf_stat_type s;
    stf_pos_type p;
    logic [27:0] frac;
    logic ch;
  } stf_snap_type;

endpackage

// >>> verification/stf_host.sv
// host terminal model: decodes 8N1 characters from txd and sends
// characters on rxd; assumes BIT matches the programmed bit time
`timescale 1ns/1ps
module stf_host #(parameter int BIT = 16)
(
  // clock
  input wire logic hclk,
  // serial line
  input wire logic txd,
  output logic rxd = 1'b1,
  // received characters
  output logic [7:0] rx_char = 8'h00,
  output logic rx_stb = 1'b0
);
  // ****
  // receiver and sender
  // ****
  always
  begin
    @(negedge txd);
    repeat (BIT / 2) @(posedge hclk);
    repeat (8)
    begin
      repeat (BIT) @(posedge hclk);
      rx_char = {txd, rx_char[7:1]};
    end
    repeat (BIT) @(posedge hclk);
    // a bad stop bit drops the character
    rx_stb <= txd;
    @(posedge hclk);
    rx_stb <= 1'b0;
  end

  task automatic send(input logic [7:0] c);
    for (int i = 0; i < 10; i++)
    begin
      rxd <= i == 0 ? 1'b0 : i == 9 ? 1'b1 : c[i - 1];
      repeat (BIT) @(posedge hclk);
    end
  endtask
endmodule

// >>> verification/serial_time_telegram_formatter_tb.sv
// bench of the telegram formatter: registers over ahb-lite, then
// time, extended, minute, request and capture telegrams checked per
// character
// assumes the host model decodes 8N1 at the bit time set here
`timescale 1ns/1ps
module serial_time_telegram_formatter_tb;
  import stf_pkg::*;
  localparam int BIT = 16;
  logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
  logic sec_tick = 1'b0;
  logic [1:0] htrans = 2'h0, cap_in = 2'h3;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0;
  logic [27:0] frac = 28'h0;
  stf_time_type tm = '0;
  stf_stat_type st = '0;
  stf_pos_type pos = '0;
  bit ext = 1'b0;
  logic hreadyout, hresp, txd, rxd, rx_stb;
  logic [31:0] hrdata, rd;
  logic [7:0] rx_char;
  logic [7:0] exp_q[$];
  logic [31:0] rs = 32'h40efa60e;
  int n_errors = 0;
  int total_checks = 0;

  always #10 hclk = ~hclk;

  stf_top u_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
    .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .sec_tick(sec_tick), .tm(tm),
    .st(st), .pos(pos), .frac(frac), .cap_in(cap_in), .rxd(rxd),
    .txd(txd));
  stf_host #(.BIT(BIT)) u_host (.hclk(hclk), .txd(txd), .rxd(rxd),
    .rx_char(rx_char), .rx_stb(rx_stb));

  // ****
  // helpers
  // ****
  task automatic check(input string nm, input logic [31:0] seen, exp);
    total_checks++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic report_and_stop();
    if (n_errors == 0 && total_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  function automatic logic [31:0] xs();
    rs ^= rs << 13;
    rs ^= rs >> 17;
    rs ^= rs << 5;
    return rs;
  endfunction

  function automatic logic [7:0] bcd(input int v);
    return {4'(v / 10), 4'(v % 10)};
  endfunction

  task automatic wait_rdy();
    int n;
    n = 0;
    do
    begin
      @(posedge hclk);
      n++;
    end
    while (hreadyout !== 1'b1 && n < 20);
    if (hreadyout !== 1'b1)
    begin
      check("bus ready", hreadyout, 1);
      report_and_stop();
    end
  endtask

  // address phase until ready, then data phase until ready
  task automatic ahb(input logic wr, input logic [31:0] a, wd);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= wr;
    htrans <= 2'h2;
    wait_rdy();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    wait_rdy();
    rd = hrdata;
    check("hresp", hresp, 0);
  endtask

  task automatic put(input string s);
    foreach (s[i])
      exp_q.push_back(s[i]);
  endtask

  task automatic rnd_time(input logic [7:0] sc);
    tm <= '{bcd(1 + xs() % 28), bcd(1 + xs() % 12), bcd(xs() % 100),
      bcd(xs() % 24), bcd(xs() % 60), sc, 4'(1 + xs() % 7)};
  endtask

  task automatic tick(input bit sent);
    int n;
    @(posedge hclk);
    sec_tick <= 1'b1;
    if (sent)
    begin
      exp_q.push_back(CH_STX);
      if (ext)
        put($sformatf("%h.%h.%h; %h; %h:%h:%h; -05:30;  #S!A %s; 52.1234N%s",
          tm.day, tm.mon, tm.yr, tm.dow, tm.hr, tm.mn, tm.sc,
          tm.sc == 8'h60 ? "L" : " ",
          "   1.3456W   75m"));
      else
        put($sformatf("D:%h.%h.%h;T:%h;U:%h.%h.%h;%s%s%s%s", tm.day, tm.mon,
          tm.yr, tm.dow, tm.hr, tm.mn, tm.sc, st.sync ? " " : "#",
          st.pos_ok ? " " : "#", st.tz == TZ_UTC ? "U" :
          st.tz == TZ_CEST ? "S" : " ", st.ann_leap ? "A" :
          st.ann_dst ? "!" : " "));
      exp_q.push_back(CH_ETX);
    end
    @(posedge hclk);
    sec_tick <= 1'b0;
    n = 0;
    do
    begin
      @(posedge hclk);
      n++;
    end
    while (txd !== 1'b0 && n < 2 * BIT);
    check("start delay", n, sent ? 3 : 2 * BIT);
  endtask

  task automatic drain();
    int n;
    n = 0;
    while (exp_q.size() != 0 && n < 14 * 66 * BIT)
    begin
      @(posedge hclk);
      n++;
    end
    check("chars left", exp_q.size(), 0);
    if (exp_q.size() != 0)
      report_and_stop();
    repeat (2 * BIT) @(posedge hclk);
  endtask

  always @(posedge hclk)
    if (rx_stb === 1'b1)
    begin
      if (exp_q.size() == 0)
        check("extra char", 1, 0);
      else
        check("char", rx_char, exp_q.pop_front());
    end

  // ****
  // main sequence
  // ****
  initial
  begin
    stf_stat_type s;
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    check("txd idle", txd, 1);
    ahb(0, CTRL_OFF, 0);
    check("ctrl reset", rd, 32'(CTRL_RST));
    ahb(0, BAUD_OFF, 0);
    check("baud reset", rd, 32'(BAUD_RST));
    ahb(1, BAUD_OFF, BIT - 1);
    ahb(0, BAUD_OFF, 0);
    check("baud", rd, BIT - 1);
    ahb(0, 32'h10000, 0);
    check("unmapped", rd, 0);
    for (int z = 0; z < 3; z++)
    begin
      s = '0;
      s.sync = z[1];
      s.pos_ok = z[0];
      s.tz = 2'(z);
      s.ann_leap = z == 1;
      s.ann_dst = z == 0;
      s.leap_now = z == 2;
      rnd_time(z == 2 ? 8'h60 : bcd(xs() % 60));
      st <= s;
      tick(1);
      drain();
    end
    ahb(1, CTRL_OFF, 32'h89);
    s = '{sync: 1'b1, pos_ok: 1'b0, tz: TZ_CEST, ann_dst: 1'b1,
      ann_leap: 1'b1, leap_now: 1'b1, off_neg: 1'b1, off_hr: 8'h05,
      off_mn: 8'h30};
    st <= s;
    pos <= '{28'h0521234, 1'b0, 28'h0013456, 1'b1, 16'h0075};
    ext = 1'b1;
    for (int e = 0; e < 2; e++)
    begin
      rnd_time(e ? 8'h60 : 8'h59);
      tick(1);
      ahb(0, STAT_OFF, 0);
      check("status", rd, 32'h3);
      drain();
    end
    ext = 1'b0;
    ahb(1, CTRL_OFF, 32'h3);
    rnd_time(8'h30);
    tick(0);
    rnd_time(8'h00);
    tick(1);
    drain();
    ahb(1, CTRL_OFF, 32'h5);
    tick(0);
    u_host.send(CH_REQ);
    repeat (BIT) @(posedge hclk);
    ahb(0, RXD_OFF, 0);
    check("rx char", rd, 32'(CH_REQ));
    tick(1);
    drain();
    for (int c = 0; c < 2; c++)
    begin
      frac <= {bcd(xs() % 100), bcd(xs() % 100), bcd(xs() % 100), 4'h7};
      cap_in <= c ? 2'h1 : 2'h2;
      @(posedge hclk);
      cap_in <= 2'h3;
      put($sformatf("CH%0d %h.%h.%h %h:%h:%h.%h", c, tm.day, tm.mon, tm.yr,
        tm.hr, tm.mn, tm.sc, frac));
      exp_q.push_back(CH_CR);
      exp_q.push_back(CH_LF);
      drain();
    end
    report_and_stop();
  end
endmodule
